//--- hdl/psc_pkg.sv
// Purpose: Shared constants for position smoothing and completion logic
// Assumes: 20 MHz clock, settings arrive as plain ports
// Notes: Times are kept in their own unit and converted to cycles here
package psc_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TIME_UNIT_US = 100; // One setting step is 0.1 ms
  localparam int UNIT_CYCLES = (CLK_HZ / 1_000_000) * TIME_UNIT_US;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int TC_W = 15;      // Smoothing time constant, 0..32767
  localparam int FREQ_W = 9;     // Vibration frequency, 50..500
  localparam int DAMP_W = 8;     // Vibration damping, 0..200
  localparam int WIN_W = 13;     // Error window, 0..5000 pulses
  localparam int SETTLE_W = 16;  // Settle time, 0..60000
  localparam int ERR_W = 32;     // Position error counter
  localparam int PRE_W = 16;     // Time unit prescaler

  // ----------------------------------------------------------------
  // Setting limits and values after reset
  // ----------------------------------------------------------------
  localparam logic [TC_W-1:0] TC_RESET = 15'h0000;
  localparam logic [FREQ_W-1:0] FREQ_MIN = 9'h032;   // 50
  localparam logic [FREQ_W-1:0] FREQ_MAX = 9'h1f4;   // 500
  localparam logic [FREQ_W-1:0] FREQ_RESET = 9'h064; // 100
  localparam logic [DAMP_W-1:0] DAMP_MAX = 8'hc8;    // 200
  localparam logic [DAMP_W-1:0] DAMP_RESET = 8'h19;  // 25

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic FO_FIRST = 1'b0;  // First-order smoothing
  localparam logic FO_SECOND = 1'b1; // Second-order smoothing
  localparam logic [1:0] MODE_SPEED = 2'h0;
  localparam logic [1:0] MODE_POS = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;

  typedef enum logic [2:0] {
    ST_MOVING = 3'b001,
    ST_SETTLE = 3'b010,
    ST_DONE = 3'b100
  } psc_state_t;

endpackage : psc_pkg

//--- hdl/psc_lag_stage.sv
// Purpose: One first-order lag stage for a pulse stream
// Assumes: At most one input pulse per clock
// Notes: Output rate is pending count over time constant in cycles
`timescale 1ns/100ps
module psc_lag_stage #(
  parameter int PW = 24,
  parameter int AW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic bypass,
  input wire logic [AW-1:0] tc_cyc,
  // Pulse in
  input wire logic in_pulse,
  input wire logic in_dir,
  // Pulse out
  output logic out_pulse,
  output logic out_dir,
  output logic idle
);

  logic signed [PW-1:0] pend_r;
  logic signed [PW-1:0] pend_nxt;
  logic [AW:0] acc_r;
  logic [AW:0] acc_nxt;
  logic out_pulse_r;
  logic out_dir_r;

  // ----------------------------------------------------------------
  // Rate decision
  // ----------------------------------------------------------------
  wire pass = bypass | (tc_cyc == '0);
  wire neg = pend_r[PW-1];
  wire [PW-1:0] mag = neg ? PW'(-pend_r) : PW'(pend_r);
  wire [AW:0] acc_sum = acc_r + (AW+1)'(mag);
  wire fire = !pass && (pend_r != '0) && (acc_sum >= {1'b0, tc_cyc});
  wire signed [PW-1:0] inc = !in_pulse ? '0 : (in_dir ? PW'(1) : PW'(-1));
  wire signed [PW-1:0] dec = !fire ? '0 : (neg ? PW'(-1) : PW'(1));

  // Pending pulses and fractional accumulator
  always_comb begin
    pend_nxt = pass ? '0 : PW'(pend_r + inc - dec);
    if (pass || pend_r == '0) begin
      acc_nxt = '0; // Fresh start avoids a burst on the next move
    end else if (fire) begin
      acc_nxt = acc_sum - {1'b0, tc_cyc};
    end else begin
      acc_nxt = acc_sum;
    end
  end

  // Registered state and outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= '0;
      acc_r <= '0;
      out_pulse_r <= 1'b0;
      out_dir_r <= 1'b1;
    end else begin
      pend_r <= pend_nxt;
      acc_r <= acc_nxt;
      out_pulse_r <= pass ? in_pulse : fire;
      out_dir_r <= pass ? in_dir : !neg;
    end
  end

  assign out_pulse = out_pulse_r;
  assign out_dir = out_dir_r;
  assign idle = (pend_r == '0);

endmodule : psc_lag_stage

//--- hdl/psc_top.sv
// Purpose: Reference smoothing, vibration settings, positioning complete
// Assumes: Pulses are gear-scaled reference units, synchronous inputs
// Notes: Order and suppression enable are caught once after reset
//
// Function
// - Smooth reference pulses, first or second order
// - Filter order adopted only after restart
// - Time constant adopted only when idle, zero error
// - Suppression works in speed and position modes
// - Enable digit: 0 disables, 1 enables suppression
// - Frequency 50..500, default 100, immediate
// - Damping 0..200, default 25, immediate
// - Completion low when done, high otherwise
// - Complete when error below window past settle
// - Error counted in gear-scaled reference units
// - Completion routable to chosen output terminal
// - Speed coincidence in speed, high in torque
`timescale 1ns/100ps
module psc_top
  import psc_pkg::*;
#(
  parameter int N_OUT = 4,
  parameter int UNIT_CYC = UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host reference and clear
  input wire logic ref_pulse,
  input wire logic ref_dir,
  input wire logic error_clear_input,
  input wire logic servo_on,
  // Motor feedback in reference units
  input wire logic fb_pulse,
  input wire logic fb_dir,
  // Mode and speed status
  input wire logic [1:0] control_mode,
  input wire logic speed_coincident,
  // Settings
  input wire logic filter_order_select,
  input wire logic [TC_W-1:0] smoothing_time_constant,
  input wire logic vibration_suppress_enable,
  input wire logic [FREQ_W-1:0] vibration_frequency_setting,
  input wire logic [DAMP_W-1:0] vibration_damping_setting,
  input wire logic [WIN_W-1:0] position_error_window,
  input wire logic [SETTLE_W-1:0] completion_settle_time,
  input wire logic [$clog2(N_OUT)-1:0] output_terminal_assignment,
  // Smoothed reference
  output logic smooth_pulse,
  output logic smooth_dir,
  // Vibration suppression
  output logic vib_active,
  output logic [FREQ_W-1:0] vib_freq_eff,
  output logic [DAMP_W-1:0] vib_damp_eff,
  // Position status
  output logic signed [ERR_W-1:0] position_error,
  output logic [TC_W-1:0] tc_active,
  output logic filter_order_active,
  output logic positioning_complete_n,
  output logic [N_OUT-1:0] out_terminal_n
);

  // ----------------------------------------------------------------
  // Restart capture
  // ----------------------------------------------------------------
  logic started_r;
  logic order_r;
  logic vib_en_r;

  // Settings caught at the first edge after reset only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      started_r <= 1'b0;
      order_r <= FO_FIRST;
      vib_en_r <= 1'b0;
    end else if (!started_r) begin
      started_r <= 1'b1;
      order_r <= filter_order_select;
      vib_en_r <= vibration_suppress_enable;
    end
  end

  // ----------------------------------------------------------------
  // Position error counter
  // ----------------------------------------------------------------
  logic signed [ERR_W-1:0] err_r;
  logic signed [ERR_W-1:0] err_nxt;

  // Reference adds, feedback subtracts, both in reference units
  wire signed [ERR_W-1:0] ref_step =
    !ref_pulse ? '0 : (ref_dir ? ERR_W'(1) : ERR_W'(-1));
  wire signed [ERR_W-1:0] fb_step =
    !fb_pulse ? '0 : (fb_dir ? ERR_W'(1) : ERR_W'(-1));
  wire err_clear = error_clear_input | !servo_on;
  wire err_zero = (err_r == '0);
  wire [ERR_W-1:0] err_mag = err_r[ERR_W-1] ? ERR_W'(-err_r) : ERR_W'(err_r);

  always_comb begin
    err_nxt = err_clear ? '0 : ERR_W'(err_r + ref_step - fb_step);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_r <= '0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Smoothing filter
  // ----------------------------------------------------------------
  logic [TC_W-1:0] tc_r;
  logic s1_pulse;
  logic s1_dir;
  logic s1_idle;
  logic s2_idle;
  logic s2_pulse;
  logic s2_dir;

  // New constant only in a quiet moment, so no pulses are lost
  wire tc_adopt = !ref_pulse && err_zero && s1_idle && s2_idle;
  wire [31:0] tc_cyc = 32'(tc_r) * 32'(UNIT_CYC);
  wire second_off = (order_r == FO_FIRST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tc_r <= TC_RESET;
    end else if (tc_adopt) begin
      tc_r <= smoothing_time_constant;
    end
  end

  // First lag always in the path; zero constant passes straight
  psc_lag_stage #(.PW(24), .AW(32)) u_lag1 (
    .clk(clk),
    .resetn(resetn),
    .bypass(1'b0),
    .tc_cyc(tc_cyc),
    .in_pulse(ref_pulse),
    .in_dir(ref_dir),
    .out_pulse(s1_pulse),
    .out_dir(s1_dir),
    .idle(s1_idle)
  );

  // Second lag gives the second-order response when selected
  psc_lag_stage #(.PW(24), .AW(32)) u_lag2 (
    .clk(clk),
    .resetn(resetn),
    .bypass(second_off),
    .tc_cyc(tc_cyc),
    .in_pulse(s1_pulse),
    .in_dir(s1_dir),
    .out_pulse(s2_pulse),
    .out_dir(s2_dir),
    .idle(s2_idle)
  );

  // ----------------------------------------------------------------
  // Vibration suppression settings
  // ----------------------------------------------------------------
  logic vib_active_r;
  logic [FREQ_W-1:0] freq_r;
  logic [DAMP_W-1:0] damp_r;

  // Out-of-range writes are clamped rather than rejected
  wire [FREQ_W-1:0] freq_clamp =
    (vibration_frequency_setting < FREQ_MIN) ? FREQ_MIN :
    (vibration_frequency_setting > FREQ_MAX) ? FREQ_MAX :
    vibration_frequency_setting;
  wire [DAMP_W-1:0] damp_clamp =
    (vibration_damping_setting > DAMP_MAX) ? DAMP_MAX :
    vibration_damping_setting;
  wire vib_mode_ok = (control_mode == MODE_SPEED) ||
    (control_mode == MODE_POS);
  wire vib_on = vib_en_r && vib_mode_ok;

  // Settings follow the ports every cycle, zero while disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vib_active_r <= 1'b0;
      freq_r <= FREQ_RESET;
      damp_r <= DAMP_RESET;
    end else begin
      vib_active_r <= vib_on;
      freq_r <= vib_on ? freq_clamp : '0;
      damp_r <= vib_on ? damp_clamp : '0;
    end
  end

  // ----------------------------------------------------------------
  // Settle timing
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] pre_r;
  logic [SETTLE_W:0] cnt_r;
  logic [SETTLE_W:0] cnt_nxt;
  psc_state_t st_r;
  psc_state_t st_nxt;

  wire tick = (pre_r == PRE_W'(UNIT_CYC - 1));
  wire in_win = (err_mag < ERR_W'(position_error_window));
  wire pos_mode = (control_mode == MODE_POS) && servo_on;
  wire settled = (cnt_r > (SETTLE_W+1)'(completion_settle_time));

  // Free-running 0.1 ms prescaler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= tick ? '0 : PRE_W'(pre_r + 1'b1);
    end
  end

  // Completion sequence; any excursion restarts the settle time
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_MOVING: begin
        cnt_nxt = '0;
        if (pos_mode && in_win) begin
          st_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!pos_mode || !in_win) begin
          st_nxt = ST_MOVING;
        end else if (settled) begin
          st_nxt = ST_DONE;
        end else if (tick && !cnt_r[SETTLE_W]) begin
          cnt_nxt = (SETTLE_W+1)'(cnt_r + 1'b1);
        end
      end
      ST_DONE: begin
        if (!pos_mode || !in_win) begin
          st_nxt = ST_MOVING;
        end
      end
      default: begin
        st_nxt = ST_MOVING;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_MOVING;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Completion output and terminal routing
  // ----------------------------------------------------------------
  logic positioning_complete_n_n_r;
  logic [N_OUT-1:0] term_n_r;
  logic positioning_complete_n_n_nxt;

  // Shared pin: completion, speed coincidence, or idle high
  always_comb begin
    if (control_mode == MODE_POS) begin
      positioning_complete_n_n_nxt = (st_r != ST_DONE);
    end else if (control_mode == MODE_SPEED) begin
      positioning_complete_n_n_nxt = !speed_coincident;
    end else begin
      positioning_complete_n_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      positioning_complete_n_n_r <= 1'b1;
      term_n_r <= '1;
    end else begin
      positioning_complete_n_n_r <= positioning_complete_n_n_nxt;
      for (int i = 0; i < N_OUT; i++) begin
        term_n_r[i] <= (output_terminal_assignment == i) ?
          positioning_complete_n_n_nxt : 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign smooth_pulse = s2_pulse;
  assign smooth_dir = s2_dir;
  assign vib_active = vib_active_r;
  assign vib_freq_eff = freq_r;
  assign vib_damp_eff = damp_r;
  assign position_error = err_r;
  assign tc_active = tc_r;
  assign filter_order_active = order_r;
  assign positioning_complete_n = positioning_complete_n_n_r;
  assign out_terminal_n = term_n_r;

endmodule : psc_top

//--- sim/psc_props.sv
// Purpose: Port-level checks on the smoothing and completion block
// Assumes: One clock, reset active low; window and settle held steady
// Notes: A counter of in-window cycles stands in for long repetitions
`timescale 1ns/100ps
module psc_props
  import psc_pkg::*;
#(
  parameter int N_OUT = 4,
  parameter int UNIT_CYC = UNIT_CYCLES
) (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic resetn,
  input wire logic ref_pulse,
  input wire logic ref_dir,
  input wire logic servo_on,
  input wire logic [1:0] control_mode,
  input wire logic speed_coincident,
  input wire logic [WIN_W-1:0] position_error_window,
  input wire logic [SETTLE_W-1:0] completion_settle_time,
  input wire logic [$clog2(N_OUT)-1:0] output_terminal_assignment,
  // Outputs
  input wire logic smooth_pulse,
  input wire logic smooth_dir,
  input wire logic vib_active,
  input wire logic [FREQ_W-1:0] vib_freq_eff,
  input wire logic [DAMP_W-1:0] vib_damp_eff,
  input wire logic signed [ERR_W-1:0] position_error,
  input wire logic [TC_W-1:0] tc_active,
  input wire logic filter_order_active,
  input wire logic positioning_complete_n,
  input wire logic [N_OUT-1:0] out_terminal_n
);
  logic [ERR_W-1:0] err_mag;
  logic in_win;
  int win_cnt_r;
  // Magnitude of error; window compare is strict
  assign err_mag = position_error[ERR_W-1] ? -position_error : position_error;
  assign in_win = err_mag < ERR_W'(position_error_window) && servo_on
    && control_mode == MODE_POS;
  // Consecutive in-window cycles, cleared on any exit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) win_cnt_r <= 0;
    else win_cnt_r <= in_win ? win_cnt_r + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_first_pass: assert property (
    ref_pulse && !filter_order_active && tc_active == 15'h0000
    |-> ##2 smooth_pulse && smooth_dir == $past(ref_dir, 2))
    else $error("first order pass-through wrong");
  chk_second_pass: assert property (
    ref_pulse && filter_order_active && tc_active == 15'h0000
    |-> ##2 smooth_pulse)
    else $error("second order pass-through wrong");
  chk_tc_hold: assert property (
    ref_pulse || position_error != 0 |=> $stable(tc_active))
    else $error("time constant taken while busy");
  chk_leave_done: assert property (
    (control_mode == MODE_POS && !in_win)[*2] |=> positioning_complete_n)
    else $error("completion held outside window");
  chk_settle_min: assert property (
    $fell(positioning_complete_n) && $past(control_mode) == MODE_POS
    |-> win_cnt_r > int'(completion_settle_time) * UNIT_CYC)
    else $error("completion before settle time");
  chk_term_route: assert property (
    $stable(output_terminal_assignment) |->
    out_terminal_n[output_terminal_assignment] == positioning_complete_n
    && $countones(out_terminal_n) >= N_OUT - 1)
    else $error("terminal routing wrong");
  chk_speed_positioning_complete_n: assert property (
    control_mode == MODE_SPEED && servo_on
    |=> positioning_complete_n == !$past(speed_coincident))
    else $error("speed coincidence wrong");
  chk_torque_off: assert property (
    control_mode == MODE_TORQUE |=> positioning_complete_n)
    else $error("completion active in torque mode");
  chk_vib_torque: assert property (
    (control_mode == MODE_TORQUE)[*2] |=> !vib_active
    && vib_freq_eff == 9'h000 && vib_damp_eff == 8'h00)
    else $error("suppression active in torque mode");
  chk_vib_range: assert property (
    vib_active |-> vib_freq_eff >= FREQ_MIN && vib_freq_eff <= FREQ_MAX
    && vib_damp_eff <= DAMP_MAX)
    else $error("suppression setting out of range");
  cover property ($fell(positioning_complete_n));
  cover property (smooth_pulse && filter_order_active);
  cover property ($changed(tc_active));
endmodule : psc_props

//--- sim/psc_host_model.sv
// Purpose: Host controller sending reference pulse bursts
// Assumes: Commands come from the bench just after clock edges
// Notes: Clear is raised only once the burst has stopped
`timescale 1ns/100ps
module psc_host_model (
  // Clock, reset and commands
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] n,
  input wire logic dir,
  input wire logic [3:0] gap,
  input wire logic clr,
  // Toward the drive
  output logic ref_pulse,
  output logic ref_dir,
  output logic error_clear_input,
  output logic busy
);
  logic [7:0] left_r;
  logic [3:0] wait_r;
  logic clr_r;
  assign busy = left_r != 8'h00 || clr_r;
  // Burst engine; gap sets a prompt or slow pulse rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_r <= 8'h00;
      wait_r <= 4'h0;
      clr_r <= 1'b0;
      ref_pulse <= 1'b0;
      ref_dir <= 1'b1;
      error_clear_input <= 1'b0;
    end else begin
      ref_pulse <= 1'b0;
      error_clear_input <= 1'b0;
      if (start) begin
        left_r <= n;
        ref_dir <= dir;
        clr_r <= clr;
        wait_r <= 4'h0;
      end else if (left_r != 8'h00) begin
        wait_r <= wait_r == 4'h0 ? gap : wait_r - 4'h1;
        ref_pulse <= wait_r == 4'h0;
        left_r <= left_r - 8'(wait_r == 4'h0);
      end else if (clr_r) begin
        error_clear_input <= 1'b1;
        clr_r <= 1'b0;
      end
    end
  end
endmodule : psc_host_model

//--- sim/psc_top_bench.sv
// Purpose: Self-checking bench for the smoothing and completion block
// Assumes: Time unit shortened to 8 clocks, four output terminals
// Notes: Feedback copies the smoothed stream while fb_en is high
`timescale 1ns/100ps
module psc_top_bench
  import psc_pkg::*;
;
  localparam int UC = 8;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ref_pulse, ref_dir, error_clear_input, h_busy, fb_en, h_start;
  logic servo_on, fb_pulse, fb_dir, speed_coincident, h_dir, h_clr;
  logic filter_order_select, vibration_suppress_enable, smooth_pulse;
  logic smooth_dir, vib_active, filter_order_active, positioning_complete_n;
  logic [1:0] control_mode, output_terminal_assignment;
  logic [7:0] h_n;
  logic [3:0] h_gap, out_terminal_n;
  logic [TC_W-1:0] smoothing_time_constant, tc_active;
  logic [FREQ_W-1:0] vibration_frequency_setting, vib_freq_eff;
  logic [DAMP_W-1:0] vibration_damping_setting, vib_damp_eff;
  logic [WIN_W-1:0] position_error_window;
  logic [SETTLE_W-1:0] completion_settle_time;
  logic signed [ERR_W-1:0] position_error;
  logic [31:0] seed = 32'h0001281e;
  int exp_err, net_ref, net_out, errors, compares;

  always #25 clk = ~clk;
  psc_top #(.N_OUT(4), .UNIT_CYC(UC)) dut (.clk(clk), .resetn(resetn),
    .ref_pulse(ref_pulse), .ref_dir(ref_dir),
    .error_clear_input(error_clear_input), .servo_on(servo_on),
    .fb_pulse(fb_pulse), .fb_dir(fb_dir), .control_mode(control_mode),
    .speed_coincident(speed_coincident),
    .filter_order_select(filter_order_select),
    .smoothing_time_constant(smoothing_time_constant),
    .vibration_suppress_enable(vibration_suppress_enable),
    .vibration_frequency_setting(vibration_frequency_setting),
    .vibration_damping_setting(vibration_damping_setting),
    .position_error_window(position_error_window),
    .completion_settle_time(completion_settle_time),
    .output_terminal_assignment(output_terminal_assignment),
    .smooth_pulse(smooth_pulse), .smooth_dir(smooth_dir),
    .vib_active(vib_active), .vib_freq_eff(vib_freq_eff),
    .vib_damp_eff(vib_damp_eff), .position_error(position_error),
    .tc_active(tc_active), .filter_order_active(filter_order_active),
    .positioning_complete_n(positioning_complete_n),
    .out_terminal_n(out_terminal_n));
  psc_host_model host (.clk(clk), .resetn(resetn), .start(h_start),
    .n(h_n), .dir(h_dir), .gap(h_gap), .clr(h_clr), .ref_pulse(ref_pulse),
    .ref_dir(ref_dir), .error_clear_input(error_clear_input), .busy(h_busy));

  function automatic int st(input logic p, d);
    return p ? (d ? 1 : -1) : 0;
  endfunction : st
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic int clampf(input int v, lo, hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : clampf
  task automatic check(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic close_out();
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic do_reset();
    resetn = 1'b0;
    tick(20);
    check("vib_freq_eff", FREQ_RESET, vib_freq_eff);
    check("vib_damp_eff", DAMP_RESET, vib_damp_eff);
    check("terminals", 4'hf, out_terminal_n);
    resetn = 1'b1;
    tick(2);
  endtask : do_reset
  // Host burst, then wait for it to finish
  task automatic send(input int n, input logic d, c);
    h_n = 8'(n);
    h_dir = d;
    h_clr = c;
    h_start = 1'b1;
    tick(1);
    h_start = 1'b0;
    for (int k = 0; k < 3000 && h_busy; k++) tick(1);
    check("host_busy", 0, h_busy);
    tick(2);
  endtask : send
  task automatic drain();
    for (int k = 0; k < 3000 && net_out != net_ref; k++) tick(1);
    check("net_out", net_ref, net_out);
  endtask : drain
  task automatic wait_low();
    for (int k = 0; k < 3000 && positioning_complete_n !== 1'b0; k++) tick(1);
    check("complete_n", 0, positioning_complete_n);
  endtask : wait_low

  // Model of error counter and net pulse counts
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_err <= 0;
      net_ref <= 0;
      net_out <= 0;
    end else begin
      exp_err <= (error_clear_input || !servo_on) ? 0 :
        exp_err + st(ref_pulse, ref_dir) - st(fb_pulse, fb_dir);
      net_ref <= net_ref + st(ref_pulse, ref_dir);
      net_out <= net_out + st(smooth_pulse, smooth_dir);
    end
  end
  // Motor follows the smoothed stream; off the edge to avoid races
  always @(posedge clk) begin
    #2;
    fb_pulse = fb_en && smooth_pulse;
    fb_dir = smooth_dir;
  end
  always @(negedge clk) if (resetn) check("err", exp_err, position_error);

  initial begin
    {servo_on, fb_en, fb_pulse, fb_dir, speed_coincident} = 5'h12;
    {h_start, h_dir, h_clr, filter_order_select} = 4'h0;
    {vibration_suppress_enable, h_n, h_gap} = 13'h1001;
    control_mode = MODE_POS;
    output_terminal_assignment = 2'h0;
    smoothing_time_constant = 15'h0000;
    vibration_frequency_setting = FREQ_RESET;
    vibration_damping_setting = DAMP_RESET;
    position_error_window = 13'h000a;
    completion_settle_time = 16'h0002;
    do_reset();
    send(5, 1'b1, 1'b0);
    drain();
    smoothing_time_constant = 15'h0003;
    tick(3);
    check("tc_active", 0, tc_active);
    send(0, 1'b0, 1'b1);
    check("tc_active", 3, tc_active);
    fb_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      h_gap = seed[7:4];
      send(4 + seed[2:0], seed[3], 1'b0);
    end
    drain();
    wait_low();
    for (int a = 0; a < 4; a++) begin
      output_terminal_assignment = 2'(a);
      tick(2);
      check("terminals", 4'(~(4'h1 << a)), out_terminal_n);
    end
    position_error_window = 13'h0000;
    tick(3);
    check("complete_n", 1, positioning_complete_n);
    position_error_window = 13'h000a;
    wait_low();
    fb_en = 1'b0;
    send(12, 1'b1, 1'b0);
    check("complete_n", 1, positioning_complete_n);
    control_mode = MODE_SPEED;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      speed_coincident = seed[0];
      tick(2);
      check("complete_n", !seed[0], positioning_complete_n);
    end
    control_mode = MODE_TORQUE;
    tick(2);
    check("complete_n", 1, positioning_complete_n);
    {filter_order_select, servo_on, vibration_suppress_enable} = 3'h4;
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      control_mode = 2'(i / 3);
      vibration_frequency_setting = seed[8:0];
      vibration_damping_setting = seed[16:9];
      tick(2);
      check("vib_active", i < 6, vib_active);
      check("vib_freq", i < 6 ? clampf(seed[8:0], 50, 500) : 0,
        vib_freq_eff);
      check("vib_damp", i < 6 ? clampf(seed[16:9], 0, 200) : 0,
        vib_damp_eff);
    end
    check("order", 0, filter_order_active);
    smoothing_time_constant = 15'h0000;
    do_reset();
    check("order", 1, filter_order_active);
    control_mode = MODE_SPEED;
    tick(2);
    check("vib_active", 0, vib_active);
    send(6, 1'b0, 1'b0);
    drain();
    smoothing_time_constant = 15'h0002;
    tick(2);
    check("tc_active", 2, tc_active);
    send(7, 1'b1, 1'b0);
    drain();
    close_out();
  end
  // Watchdog sized well past the expected run
  initial begin
    #2000000;
    errors++;
    close_out();
  end
endmodule : psc_top_bench

bind psc_top psc_props #(.N_OUT(N_OUT), .UNIT_CYC(UNIT_CYC)) u_props (
  .clk(clk), .resetn(resetn), .ref_pulse(ref_pulse), .ref_dir(ref_dir),
  .servo_on(servo_on), .control_mode(control_mode),
  .speed_coincident(speed_coincident),
  .position_error_window(position_error_window),
  .completion_settle_time(completion_settle_time),
  .output_terminal_assignment(output_terminal_assignment),
  .smooth_pulse(smooth_pulse), .smooth_dir(smooth_dir),
  .vib_active(vib_active), .vib_freq_eff(vib_freq_eff),
  .vib_damp_eff(vib_damp_eff), .position_error(position_error),
  .tc_active(tc_active), .filter_order_active(filter_order_active),
  .positioning_complete_n(positioning_complete_n),
  .out_terminal_n(out_terminal_n));
